// file: sdi_dcnt.sv
// Loadable down counter used for refresh intervals and command waits.
`timescale 1ns/1ps
module sdi_dcnt #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic zero
);

	// The whole state is the count.
	typedef struct packed {
		logic [W-1:0] cnt; // Cycles left.
	} sdi_cnt_state_t;

	sdi_cnt_state_t r_ff; // Registered state.
	sdi_cnt_state_t nxt_r; // Next state.

	// Load wins; otherwise count down and rest at zero.
	always_comb begin
		nxt_r = r_ff;
		if (load) begin
			nxt_r.cnt = value;
		end else if (r_ff.cnt != '0) begin
			nxt_r.cnt = r_ff.cnt - 1'b1;
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			r_ff <= '0;
		end else if (ce) begin
			r_ff <= nxt_r;
		end
	end

	assign zero = (r_ff.cnt == '0);

endmodule : sdi_dcnt

// file: sdi_mem_model.sv
// Behavioural SDRAM device that logs the command stream it receives.
`timescale 1ns/1ps
module sdi_mem_model (
	input wire logic mclk,
	input wire logic clear,
	input wire logic cke,
	input wire logic [3:0] cmd,
	input wire logic [12:0] addr,
	output logic [7:0] pre_cnt,
	output logic [7:0] ref_cnt,
	output logic [9:0] mode,
	output logic a10_low,
	output logic [15:0] nop_max,
	output logic [15:0] cke_gap
);
	logic [15:0] run; // NOP cycles since the last real command.
	logic cke_d; // Clock enable seen one edge ago.
	logic gap_on; // High while timing the wake-up gap.
	////////////////////////////////////////////////////////////////////////////
	// The device only sees the wires at its clock edge, so all logging is edge based.
	always @(posedge mclk) begin
		cke_d <= cke;
		if (clear) begin
			pre_cnt <= 8'h00;
			ref_cnt <= 8'h00;
			mode <= 10'h000;
			a10_low <= 1'b0;
			nop_max <= 16'h0000;
			run <= 16'h0000;
		end else if (cmd == sdi_pkg::CMD_NOP) begin
			run <= run + 16'h0001;
			if (run >= nop_max) nop_max <= run + 16'h0001;
		end else begin
			run <= 16'h0000;
			if (cmd == sdi_pkg::CMD_PRE) pre_cnt <= pre_cnt + 8'h01;
			if (cmd == sdi_pkg::CMD_PRE && !addr[10]) a10_low <= 1'b1;
			if (cmd == sdi_pkg::CMD_REF) ref_cnt <= ref_cnt + 8'h01;
			if (cmd == sdi_pkg::CMD_LMR) mode <= addr[9:0];
		end
		// A wake-up is timed from the rise of clock enable to the first command.
		if (cke && !cke_d) begin
			gap_on <= 1'b1;
			cke_gap <= 16'h0000;
		end else if (gap_on && cmd == sdi_pkg::CMD_NOP) begin
			cke_gap <= cke_gap + 16'h0001;
		end else begin
			gap_on <= 1'b0;
		end
	end
endmodule : sdi_mem_model

// file: sdi_pkg.sv
// Shared constants and types for the SDRAM initialization sequencer.
package sdi_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFS_CONFIG = 8'h00; // SDRAM configuration.
	localparam logic [7:0] OFS_REFRESH = 8'h04; // Refresh rate divisor.
	localparam logic [7:0] OFS_TIMING = 8'h08; // Command timing fields.
	localparam logic [7:0] OFS_SR_EXIT = 8'h0C; // Self refresh exit count.
	localparam logic [7:0] OFS_STATUS = 8'h10; // Read-only sequencer state.

	////////////////////////////////////////////////////////////////////////////
	// Field positions in the configuration register.
	localparam int CFG_SELF_REFRESH = 31; // Top byte, never restarts the sequence.
	localparam int CFG_NARROW = 14; // Narrow bus select.
	localparam int CFG_CL_LSB = 9; // CAS latency, three bits.
	localparam int CFG_UNLOCK = 8; // Latency write unlock, write only.
	localparam int CL_W = 3; // Width of the CAS latency field.

	// Field positions in the timing register.
	localparam int TIM_RFC_LSB = 27; // Refresh cycle time, five bits.
	localparam int TIM_RP_LSB = 24; // Precharge time, three bits.
	localparam int TIM_RCD_LSB = 20; // Activate to access time, three bits.
	localparam int TIM_WR_LSB = 16; // Write recovery time, three bits.
	localparam int TIM_RAS_LSB = 12; // Active to precharge time, four bits.
	localparam int TIM_RC_LSB = 8; // Row cycle time, four bits.
	localparam int TIM_RRD_LSB = 4; // Row to row delay, three bits.
	localparam int RFC_W = 5; // Width of the refresh cycle field.
	localparam int RP_W = 3; // Width of the precharge field.

	////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [12:0] RR_RST = 13'h0100; // Refresh rate divisor.
	localparam logic [31:0] TIM_RST = 32'hFF7F_FF70; // Slowest legal timing.
	localparam logic [7:0] TXS_RST = 8'hFF; // Self refresh exit count.
	localparam logic [2:0] CL_RST = 3'h3; // CAS latency three.
	localparam logic NARROW_RST = 1'b1; // 16-bit data bus.

	////////////////////////////////////////////////////////////////////////////
	// Timing counts.
	localparam int NOP_INTERVALS = 8; // Refresh intervals of NOP at start.
	localparam int INIT_REFRESHES = 8; // Auto refreshes after the precharge.
	localparam int CLK_PERIOD_NS = 40; // Memory clock period.
	localparam int MRD_NS = 80; // Mode register load to next command.
	localparam logic [7:0] MRD_CYC = 8'((MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////
	// Commands as {cs_n, ras_n, cas_n, we_n}.
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_LMR = 4'h0;
	localparam int A10 = 10; // Address bit that selects all banks.

	// Burst length codes in the mode value.
	localparam logic [2:0] BL4_CODE = 3'h2;
	localparam logic [2:0] BL8_CODE = 3'h3;

	// Sequencer states.
	typedef enum logic [3:0] {
		st_start, st_pre0, st_nopw, st_pre, st_aref, st_lmr,
		st_fpre, st_fref, st_wait, st_idle, st_sref, st_srh
	} sdi_st_t;

	// Mode value: no write burst option, sequential bursts, latency and length.
	function automatic logic [9:0] sdi_mode(input logic [2:0] cl, input logic narrow);
		sdi_mode = {3'h0, cl, 1'b0, narrow ? BL8_CODE : BL4_CODE};
	endfunction : sdi_mode

endpackage : sdi_pkg

// file: sdi_seq.sv
// SDRAM initialization sequencer with refresh, timing and self refresh settings.
//
// What this block does
// - Schedules refreshes from a programmable rate divisor.
// - Holds timing fields; waits precharge and refresh cycle times between commands.
// - Waits the exit count after self refresh.
// - Runs initialization on reset; no access before.
// - Low config bytes restart init; top byte not.
// - Sequence runs whether or not memory present.
// - On write restart, precharge all if bank open.
// - Clock enable high, NOPs for eight intervals.
// - One interval equals divisor memory clock cycles.
// - Then precharge all with address bit 10.
// - Then exactly eight auto refresh commands.
// - Then load mode on address bits 9:0.
// - Mode: zero top bits, sequential, CAS latency.
// - Burst length four or eight from narrow select.
// - Finish: precharge if bank open, then refresh.
`timescale 1ns/1ps
module sdi_seq #(
	parameter int AW = 13
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bank_open,
	input wire logic mem_req,
	output logic mem_grant,
	output logic init_done,
	output logic sdram_clock_enable_out,
	output logic sdram_cs_n,
	output logic sdram_ras_n,
	output logic sdram_cas_n,
	output logic sdram_we_n,
	output logic [AW-1:0] memory_address_bus
);

	////////////////////////////////////////////////////////////////////////////
	// Every flip-flop of the block, apart from the two timers and the check helper counters, lives in this one struct.
	typedef struct packed {
		sdi_pkg::sdi_st_t st; // Current state.
		sdi_pkg::sdi_st_t ret; // State to resume after a wait.
		logic [3:0] cnt; // Interval or refresh counter.
		logic by_write; // Sequence was started by a config write.
		logic final_ref; // The refresh in progress ends initialization.
		logic ref_pend; // A periodic refresh is due.
		logic iv_restart; // Restart the interval timer.
		logic self_refresh; // Self refresh request.
		logic narrow; // Narrow bus select.
		logic [2:0] cl; // CAS latency setting.
		logic [12:0] rr; // Refresh rate divisor.
		logic [31:0] tim; // Timing fields.
		logic [7:0] txs; // Self refresh exit cycles.
		logic [3:0] cmd; // Command on the pins.
		logic [AW-1:0] addr; // Address on the pins.
		logic cke; // Clock enable pin.
		logic done; // Initialization finished.
		logic grant; // Request granted.
		logic pready; // APB ready.
		logic pslverr; // APB error for unmapped offsets.
		logic [31:0] prdata; // APB read data.
	} sdi_seq_state_t;

	sdi_seq_state_t r_ff; // Registered state.
	sdi_seq_state_t nxt_r; // Next state.

	logic iv_zero; // Interval timer at zero.
	logic iv_load; // Reload the interval timer.
	logic [12:0] iv_val; // Value loaded into the interval timer.
	logic wt_zero; // Wait timer at zero.
	logic wt_load; // Load the wait timer.
	logic [7:0] wt_val; // Value loaded into the wait timer.
	logic iv_evt; // One refresh interval has elapsed.
	logic apb_wr; // APB write completes this cycle.
	logic cfg_low_wr; // Write touching the low config bytes.

	////////////////////////////////////////////////////////////////////////////
	// Interval timer: reloading with divisor minus one gives a period of
	// exactly the divisor in cycles; a zero divisor degrades to every cycle.
	assign iv_evt = iv_zero && !r_ff.iv_restart;
	assign iv_load = iv_zero || r_ff.iv_restart;
	assign iv_val = (r_ff.rr == 13'h0000) ? 13'h0000 : r_ff.rr - 13'h0001;

	sdi_dcnt #(.W(13)) u_interval (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.load(iv_load),
		.value(iv_val),
		.zero(iv_zero)
	);

	// Wait timer for spacing commands; loaded from the sequencer below.
	sdi_dcnt #(.W(8)) u_wait (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.load(wt_load),
		.value(wt_val),
		.zero(wt_zero)
	);

	assign apb_wr = psel && penable && pwrite && r_ff.pready;
	assign cfg_low_wr = apb_wr && (paddr == sdi_pkg::OFS_CONFIG) && (|pstrb[2:0]);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus slave, then the command sequencer.
	always_comb begin
		nxt_r = r_ff;
		wt_load = 1'b0;
		wt_val = 8'h00;
		// Pins default to NOP each cycle; commands last one cycle.
		nxt_r.cmd = sdi_pkg::CMD_NOP;
		nxt_r.addr = '0;
		nxt_r.iv_restart = 1'b0;
		nxt_r.grant = 1'b0;

		// Zero-wait slave: data and ready are prepared in the setup phase.
		nxt_r.pready = psel && !penable;
		nxt_r.pslverr = 1'b0;
		nxt_r.prdata = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				sdi_pkg::OFS_CONFIG: begin
					nxt_r.prdata[sdi_pkg::CFG_SELF_REFRESH] = r_ff.self_refresh;
					nxt_r.prdata[sdi_pkg::CFG_NARROW] = r_ff.narrow;
					nxt_r.prdata[sdi_pkg::CFG_CL_LSB +: sdi_pkg::CL_W] = r_ff.cl;
				end
				sdi_pkg::OFS_REFRESH: nxt_r.prdata[12:0] = r_ff.rr;
				sdi_pkg::OFS_TIMING: nxt_r.prdata = r_ff.tim;
				sdi_pkg::OFS_SR_EXIT: nxt_r.prdata[7:0] = r_ff.txs;
				sdi_pkg::OFS_STATUS: nxt_r.prdata[5:0] = {r_ff.st, r_ff.cke, r_ff.done};
				default: nxt_r.pslverr = 1'b1;
			endcase
		end

		// Register writes take effect at the access-phase edge, per byte lane.
		if (apb_wr) begin
			case (paddr)
				sdi_pkg::OFS_CONFIG: begin
					if (pstrb[3]) begin
						nxt_r.self_refresh = pwdata[sdi_pkg::CFG_SELF_REFRESH];
					end
					if (pstrb[1]) begin
						nxt_r.narrow = pwdata[sdi_pkg::CFG_NARROW];
						// Latency changes only with the unlock bit in the same write.
						if (pwdata[sdi_pkg::CFG_UNLOCK]) begin
							nxt_r.cl = pwdata[sdi_pkg::CFG_CL_LSB +: sdi_pkg::CL_W];
						end
					end
				end
				sdi_pkg::OFS_REFRESH: begin
					if (pstrb[0]) nxt_r.rr[7:0] = pwdata[7:0];
					if (pstrb[1]) nxt_r.rr[12:8] = pwdata[12:8];
					nxt_r.iv_restart = |pstrb[1:0];
				end
				sdi_pkg::OFS_TIMING: begin
					for (int b = 0; b < 4; b++) begin
						if (pstrb[b]) nxt_r.tim[b*8 +: 8] = pwdata[b*8 +: 8];
					end
				end
				sdi_pkg::OFS_SR_EXIT: begin
					if (pstrb[0]) nxt_r.txs = pwdata[7:0];
				end
				default: ;
			endcase
		end

		// A refresh falls due each interval; a new one wins over the take.
		if (iv_evt) begin
			nxt_r.ref_pend = 1'b1;
		end

		case (r_ff.st)
			// Precharge first only when software restarted with a bank open.
			sdi_pkg::st_pre0: begin
				if (r_ff.by_write && bank_open) begin
					nxt_r.cmd = sdi_pkg::CMD_PRE;
					nxt_r.addr[sdi_pkg::A10] = 1'b1;
					wt_load = 1'b1;
					wt_val = 8'(r_ff.tim[sdi_pkg::TIM_RP_LSB +: sdi_pkg::RP_W]);
					nxt_r.ret = sdi_pkg::st_start;
					nxt_r.st = sdi_pkg::st_wait;
				end else begin
					nxt_r.st = sdi_pkg::st_start;
				end
			end
			// The wait starts on a fresh interval so all eight are whole.
			sdi_pkg::st_start: begin
				nxt_r.cke = 1'b1;
				nxt_r.iv_restart = 1'b1;
				nxt_r.cnt = 4'h0;
				nxt_r.st = sdi_pkg::st_nopw;
			end
			// NOPs only; the memory may or may not be there.
			sdi_pkg::st_nopw: begin
				if (iv_evt) begin
					nxt_r.cnt = r_ff.cnt + 4'h1;
					if (r_ff.cnt == 4'(sdi_pkg::NOP_INTERVALS - 1)) begin
						nxt_r.st = sdi_pkg::st_pre;
					end
				end
			end
			sdi_pkg::st_pre: begin
				nxt_r.cmd = sdi_pkg::CMD_PRE;
				nxt_r.addr[sdi_pkg::A10] = 1'b1;
				nxt_r.cnt = 4'h0;
				wt_load = 1'b1;
				wt_val = 8'(r_ff.tim[sdi_pkg::TIM_RP_LSB +: sdi_pkg::RP_W]);
				nxt_r.ret = sdi_pkg::st_aref;
				nxt_r.st = sdi_pkg::st_wait;
			end
			// Each refresh is spaced by the refresh cycle time.
			sdi_pkg::st_aref: begin
				nxt_r.cmd = sdi_pkg::CMD_REF;
				nxt_r.cnt = r_ff.cnt + 4'h1;
				wt_load = 1'b1;
				wt_val = 8'(r_ff.tim[sdi_pkg::TIM_RFC_LSB +: sdi_pkg::RFC_W]);
				if (r_ff.cnt == 4'(sdi_pkg::INIT_REFRESHES - 1)) begin
					nxt_r.ret = sdi_pkg::st_lmr;
				end else begin
					nxt_r.ret = sdi_pkg::st_aref;
				end
				nxt_r.st = sdi_pkg::st_wait;
			end
			sdi_pkg::st_lmr: begin
				nxt_r.cmd = sdi_pkg::CMD_LMR;
				nxt_r.addr[9:0] = sdi_pkg::sdi_mode(r_ff.cl, r_ff.narrow);
				wt_load = 1'b1;
				wt_val = sdi_pkg::MRD_CYC;
				nxt_r.final_ref = 1'b1;
				nxt_r.ret = sdi_pkg::st_fpre;
				nxt_r.st = sdi_pkg::st_wait;
			end
			// Refresh cycle, shared by the end of init and the periodic path.
			sdi_pkg::st_fpre: begin
				if (bank_open) begin
					nxt_r.cmd = sdi_pkg::CMD_PRE;
					nxt_r.addr[sdi_pkg::A10] = 1'b1;
					wt_load = 1'b1;
					wt_val = 8'(r_ff.tim[sdi_pkg::TIM_RP_LSB +: sdi_pkg::RP_W]);
					nxt_r.ret = sdi_pkg::st_fref;
					nxt_r.st = sdi_pkg::st_wait;
				end else begin
					nxt_r.st = sdi_pkg::st_fref;
				end
			end
			sdi_pkg::st_fref: begin
				nxt_r.cmd = sdi_pkg::CMD_REF;
				wt_load = 1'b1;
				wt_val = 8'(r_ff.tim[sdi_pkg::TIM_RFC_LSB +: sdi_pkg::RFC_W]);
				nxt_r.ret = sdi_pkg::st_idle;
				nxt_r.st = sdi_pkg::st_wait;
			end
			// Done is raised only after the last refresh has had its full time.
			sdi_pkg::st_wait: begin
				if (wt_zero) begin
					nxt_r.st = r_ff.ret;
					if (r_ff.ret == sdi_pkg::st_idle && r_ff.final_ref) begin
						nxt_r.done = 1'b1;
						nxt_r.final_ref = 1'b0;
					end
				end
			end
			// Self refresh beats a due refresh, since the memory refreshes itself.
			sdi_pkg::st_idle: begin
				nxt_r.grant = mem_req && r_ff.done;
				if (r_ff.self_refresh && bank_open) begin
					nxt_r.cmd = sdi_pkg::CMD_PRE;
					nxt_r.addr[sdi_pkg::A10] = 1'b1;
					wt_load = 1'b1;
					wt_val = 8'(r_ff.tim[sdi_pkg::TIM_RP_LSB +: sdi_pkg::RP_W]);
					nxt_r.ret = sdi_pkg::st_idle;
					nxt_r.st = sdi_pkg::st_wait;
					nxt_r.grant = 1'b0;
				end else if (r_ff.self_refresh) begin
					nxt_r.st = sdi_pkg::st_sref;
					nxt_r.grant = 1'b0;
				end else if (r_ff.ref_pend) begin
					nxt_r.ref_pend = iv_evt;
					nxt_r.st = sdi_pkg::st_fpre;
					nxt_r.grant = 1'b0;
				end
			end
			sdi_pkg::st_sref: begin
				nxt_r.cmd = sdi_pkg::CMD_REF;
				nxt_r.cke = 1'b0;
				nxt_r.st = sdi_pkg::st_srh;
			end
			// On exit, hold NOPs for the programmed count before any command.
			sdi_pkg::st_srh: begin
				if (!r_ff.self_refresh) begin
					nxt_r.cke = 1'b1;
					wt_load = 1'b1;
					wt_val = r_ff.txs;
					nxt_r.ret = sdi_pkg::st_idle;
					nxt_r.st = sdi_pkg::st_wait;
				end
			end
			default: nxt_r.st = sdi_pkg::st_start;
		endcase

		// A low-byte config write restarts from scratch, even mid-sequence;
		// a top-byte write only changes the self refresh request.
		if (cfg_low_wr) begin
			nxt_r.st = sdi_pkg::st_pre0;
			nxt_r.by_write = 1'b1;
			nxt_r.done = 1'b0;
			nxt_r.final_ref = 1'b0;
			nxt_r.grant = 1'b0;
			// A restart must not wake a memory in self refresh without its exit count.
			if (r_ff.st == sdi_pkg::st_sref) begin
				nxt_r.cmd = sdi_pkg::CMD_NOP;
				nxt_r.cke = r_ff.cke;
			end else if (r_ff.st == sdi_pkg::st_srh) begin
				nxt_r.cke = 1'b1;
				wt_load = 1'b1;
				wt_val = r_ff.txs;
				nxt_r.ret = sdi_pkg::st_pre0;
				nxt_r.st = sdi_pkg::st_wait;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register. Reset enters the sequence directly, without the
	// opening precharge, because no bank can be open after reset.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			r_ff <= '0;
			r_ff.st <= sdi_pkg::st_start;
			r_ff.ret <= sdi_pkg::st_idle;
			r_ff.cmd <= sdi_pkg::CMD_NOP;
			r_ff.narrow <= sdi_pkg::NARROW_RST;
			r_ff.cl <= sdi_pkg::CL_RST;
			r_ff.rr <= sdi_pkg::RR_RST;
			r_ff.tim <= sdi_pkg::TIM_RST;
			r_ff.txs <= sdi_pkg::TXS_RST;
		end else if (ce) begin
			r_ff <= nxt_r;
		end
	end

	assign prdata = r_ff.prdata;
	assign pready = r_ff.pready;
	assign pslverr = r_ff.pslverr;
	assign mem_grant = r_ff.grant;
	assign init_done = r_ff.done;
	assign sdram_clock_enable_out = r_ff.cke;
	assign {sdram_cs_n, sdram_ras_n, sdram_cas_n, sdram_we_n} = r_ff.cmd;
	assign memory_address_bus = r_ff.addr;

	////////////////////////////////////////////////////////////////////////////
	// Checks. Helper counters: refreshes since the last precharge, and
	// cycles since the clock enable came back from self refresh.
	logic [3:0] h_aref_ff; // Refreshes since the last precharge.
	logic [7:0] h_xs_ff; // Cycles since self refresh exit began.

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			h_aref_ff <= 4'h0;
			h_xs_ff <= 8'hFF;
		end else if (ce) begin
			if (r_ff.cmd == sdi_pkg::CMD_PRE) h_aref_ff <= 4'h0;
			else if (r_ff.cmd == sdi_pkg::CMD_REF && h_aref_ff != 4'hF) h_aref_ff <= h_aref_ff + 4'h1;
			if (r_ff.st == sdi_pkg::st_srh) h_xs_ff <= 8'h00;
			else if (h_xs_ff != 8'hFF) h_xs_ff <= h_xs_ff + 8'h01;
		end
	end

	default clocking sdi_cb @(posedge mclk iff ce);
	endclocking
	default disable iff (!rstn);

	a_grant_after_done: assert property (mem_grant |-> init_done)
		else $error("request granted before initialization finished");
	a_low_write_restart: assert property (cfg_low_wr |=> !init_done
		&& (r_ff.st == sdi_pkg::st_pre0 || r_ff.st == sdi_pkg::st_wait))
		else $error("low config byte write did not restart initialization");
	a_top_write_keep: assert property (apb_wr && paddr == sdi_pkg::OFS_CONFIG
		&& pstrb == 4'h8 && init_done |=> init_done)
		else $error("top byte config write restarted initialization");
	a_nop_wait_cke: assert property (r_ff.st == sdi_pkg::st_nopw |=>
		sdram_clock_enable_out
		&& {sdram_cs_n, sdram_ras_n, sdram_cas_n, sdram_we_n} == sdi_pkg::CMD_NOP)
		else $error("clock enable low or command issued during the power-up wait");
	a_precharge_all: assert property (r_ff.cmd == sdi_pkg::CMD_PRE |-> memory_address_bus[10])
		else $error("precharge issued without all-bank select");
	a_eight_refreshes: assert property (r_ff.cmd == sdi_pkg::CMD_LMR |-> h_aref_ff == 4'h8)
		else $error("mode load not preceded by exactly eight refreshes");
	a_mode_value: assert property (r_ff.cmd == sdi_pkg::CMD_LMR |->
		memory_address_bus[9:0] == sdi_pkg::sdi_mode($past(r_ff.cl), $past(r_ff.narrow)))
		else $error("mode value does not match latency and bus width");
	a_mode_fixed_bits: assert property (r_ff.cmd == sdi_pkg::CMD_LMR |->
		memory_address_bus[9:7] == 3'h0 && !memory_address_bus[3])
		else $error("mode value reserved or burst type bits not zero");
	// The width select is taken from before the edge that launched the command.
	a_burst_length: assert property (r_ff.cmd == sdi_pkg::CMD_LMR |->
		memory_address_bus[2:0]
		== ($past(r_ff.narrow) ? sdi_pkg::BL8_CODE : sdi_pkg::BL4_CODE))
		else $error("burst length code does not follow the narrow select");
	a_exit_wait: assert property (r_ff.cmd != sdi_pkg::CMD_NOP && r_ff.cke
		|-> h_xs_ff >= r_ff.txs)
		else $error("command issued before the self refresh exit count");
	a_done_after_ref: assert property ($rose(init_done) |->
		$past(r_ff.st) == sdi_pkg::st_wait && $past(r_ff.ret) == sdi_pkg::st_idle)
		else $error("initialization finished without a closing refresh");

	c_init_done: cover property ($rose(init_done));
	c_restart: cover property (cfg_low_wr && init_done);
	c_self_exit: cover property ($rose(sdram_clock_enable_out) && init_done);
	c_periodic_ref: cover property (init_done && r_ff.cmd == sdi_pkg::CMD_REF);

endmodule : sdi_seq

// file: tb_sdi_seq.sv
// Self-checking testbench for the SDRAM initialization sequencer.
`timescale 1ns/1ps
module tb_sdi_seq;
	typedef struct packed {logic [3:0] s; logic [31:0] d; logic bo; logic [9:0] m;
		logic [7:0] p;} sdi_row_t;
	logic mclk, rstn, psel, penable, pwrite, bank_open, mem_req, clear, err, rdy;
	logic pready, pslverr, mem_grant, init_done, cke, cs_n, ras_n, cas_n, we_n;
	logic [7:0] paddr, pre_cnt, ref_cnt;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [12:0] addr;
	logic [9:0] mode;
	logic a10_low;
	logic [15:0] nop_max, cke_gap;
	logic [39:0] rv [4];
	sdi_row_t rows [4];
	int mismatches, checks, bad_grant, grants;
	sdi_seq u_sdi_seq (.mclk(mclk), .rstn(rstn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bank_open(bank_open), .mem_req(mem_req),
		.mem_grant(mem_grant), .init_done(init_done), .sdram_clock_enable_out(cke),
		.sdram_cs_n(cs_n), .sdram_ras_n(ras_n), .sdram_cas_n(cas_n), .sdram_we_n(we_n),
		.memory_address_bus(addr));
	sdi_mem_model u_sdi_mem_model (.mclk(mclk), .clear(clear), .cke(cke),
		.cmd({cs_n, ras_n, cas_n, we_n}), .addr(addr), .pre_cnt(pre_cnt), .ref_cnt(ref_cnt),
		.mode(mode), .a10_low(a10_low), .nop_max(nop_max), .cke_gap(cke_gap));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		if (mismatches == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// The request stands until ready is seen high at a rising edge; data is taken there.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			{rdy, err, rd} = {pready, pslverr, prdata};
			n++;
		end while (rdy !== 1'b1 && n < 50);
		{psel, penable} <= 2'b00;
		chk(rdy, 1'b1);
	endtask : apb
	task automatic wait_done();
		int n;
		n = 0;
		while (init_done !== 1'b1 && n < 20000) begin
			@(posedge mclk);
			n++;
		end
	endtask : wait_done
	////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Grants are only legal once the sequence has finished.
	always @(negedge mclk) begin
		if (mem_grant === 1'b1 && mem_req && init_done !== 1'b1) bad_grant++;
		if (mem_grant === 1'b1) grants++;
	end
	initial begin
		repeat (30000) @(posedge mclk);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{clear, mem_req, bank_open} = 3'b110;
		rv = '{{sdi_pkg::OFS_CONFIG, 32'h0000_4600}, {sdi_pkg::OFS_REFRESH, 32'h0000_0100},
			{sdi_pkg::OFS_TIMING, 32'hFF7F_FF70}, {sdi_pkg::OFS_SR_EXIT, 32'h0000_00FF}};
		rows = '{{4'h3, 32'h0000_4500, 1'b0, 10'h023, 8'h01},
			{4'h2, 32'h0000_0700, 1'b1, 10'h032, 8'h03},
			{4'h2, 32'h0000_4400, 1'b0, 10'h033, 8'h01},
			{4'h4, 32'h0000_0000, 1'b1, 10'h033, 8'h03}};
		repeat (16) @(posedge mclk);
		chk({cke, cs_n, ras_n, cas_n, we_n, init_done}, {1'b0, sdi_pkg::CMD_NOP, 1'b0});
		{rstn, clear} <= 2'b10;
		foreach (rv[i]) begin
			apb(1'b0, rv[i][39:32], 32'h0000_0000, 4'h0);
			chk(rd, rv[i][31:0]);
		end
		wait_done();
		chk(pre_cnt, 8'h01);
		chk(ref_cnt, 8'h09);
		chk(mode, 10'h033);
		chk(nop_max >= 16'd2048 && nop_max <= 16'd2060, 1'b1);
		// A due refresh goes first, so grants may start only a refresh cycle later.
		repeat (100) @(posedge mclk);
		chk(bad_grant == 0 && grants > 0, 1'b1);
		mem_req <= 1'b0;
		apb(1'b1, sdi_pkg::OFS_REFRESH, 32'h0000_0040, 4'hF);
		apb(1'b1, sdi_pkg::OFS_SR_EXIT, 32'h0000_0008, 4'hF);
		// Ordinary restarts: each row is a configuration write and the sequence it yields.
		foreach (rows[i]) begin
			{bank_open, clear} <= {rows[i].bo, 1'b1};
			apb(1'b1, sdi_pkg::OFS_CONFIG, rows[i].d, rows[i].s);
			// Keep clearing one more edge, so a command launched with the write is not logged.
			@(posedge mclk);
			clear <= 1'b0;
			@(posedge mclk);
			chk(init_done, 1'b0);
			wait_done();
			chk(pre_cnt, rows[i].p);
			chk(ref_cnt, 8'h09);
			chk(mode, rows[i].m);
			chk(nop_max >= 16'd512 && nop_max <= 16'd524, 1'b1);
		end
		// Top byte only: self refresh entry and exit must not restart the sequence.
		// The banks are closed after the closing precharge, so the entry is not held off.
		bank_open <= 1'b0;
		apb(1'b1, sdi_pkg::OFS_CONFIG, 32'h8000_0000, 4'h8);
		repeat (60) @(posedge mclk);
		chk(cke, 1'b0);
		apb(1'b1, sdi_pkg::OFS_CONFIG, 32'h0000_0000, 4'h8);
		repeat (100) @(posedge mclk);
		chk(cke_gap >= 16'd8, 1'b1);
		chk(init_done, 1'b1);
		// Periodic refresh over ten intervals of 64 cycles.
		{bank_open, clear} <= 2'b01;
		@(posedge mclk);
		clear <= 1'b0;
		repeat (640) @(posedge mclk);
		chk(ref_cnt >= 8'd9 && ref_cnt <= 8'd11, 1'b1);
		chk(a10_low, 1'b0);
		apb(1'b0, 8'h14, 32'h0000_0000, 4'h0);
		chk({err, rd}, {1'b1, 32'h0000_0000});
		apb(1'b0, sdi_pkg::OFS_STATUS, 32'h0000_0000, 4'h0);
		chk(rd[1:0], 2'b11);
		tally_and_finish();
	end
endmodule : tb_sdi_seq
